// >>> src/cpgb_top.sv
// cpgb_top: axi4-lite slave holding the capture/compare power gate register
// assumes: one clock aclk, synchronous active-low reset, one master
//
// Operation
// - a one in a disable bit shuts off that unit's power and clock
// - a zero in a disable bit keeps that unit's power and clock running
// - capture units one to three disable bits sit at bits 8, 9, 10
// - capture units four to six disable bits sit at bits 11, 12, 13
// - compare units one to six disable bits sit at bits 0 to 5
`default_nettype none
module cpgb_top (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // axi4-lite write response
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  // axi4-lite read data
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // capture unit gates, bit 0 = unit one
  output var  logic [5:0]  capture_clk_en,
  output var  logic [5:0]  capture_pwr_en,
  // compare unit gates, bit 0 = unit one
  output var  logic [5:0]  compare_clk_en,
  output var  logic [5:0]  compare_pwr_en
);
  typedef struct packed {
    logic        aw_held;
    logic [3:0]  aw_addr;
    logic        w_held;
    logic [15:0] w_data;
    logic [1:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [15:0] dis;
  } cpgb_state_t;

  cpgb_state_t st_ff;
  cpgb_state_t nxt_st;
  logic [15:0] gate_status;
  logic [5:0]  cap_clk;
  logic [5:0]  cmp_clk;

  // one channel per payload: take aw and w in either order, answer when both held
  always_comb begin
    nxt_st = st_ff;
    if (s_axi_awvalid && !st_ff.aw_held) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr[cpgb_pkg::ADDR_W-1:0];
    end
    if (s_axi_wvalid && !st_ff.w_held) begin
      nxt_st.w_held = 1'b1;
      nxt_st.w_data = s_axi_wdata[cpgb_pkg::REG_W-1:0];
      nxt_st.w_strb = s_axi_wstrb[1:0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // commit only once both halves are in and no response is pending
    if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      if (st_ff.aw_addr == cpgb_pkg::CAPTURE_COMPARE_DISABLE_OFS) begin
        nxt_st.bresp = cpgb_pkg::RESP_OKAY;
        // byte lanes: lane 0 holds compare bits, lane 1 capture bits
        if (st_ff.w_strb[0]) begin
          nxt_st.dis[7:0] = st_ff.w_data[7:0] & cpgb_pkg::IMPL_MASK[7:0];
        end
        if (st_ff.w_strb[1]) begin
          nxt_st.dis[15:8] = st_ff.w_data[15:8] & cpgb_pkg::IMPL_MASK[15:8];
        end
      end else if (st_ff.aw_addr == cpgb_pkg::GATE_STATUS_OFS) begin
        nxt_st.bresp = cpgb_pkg::RESP_OKAY; // status word is read-only, write dropped
      end else begin
        nxt_st.bresp = cpgb_pkg::RESP_SLVERR;
      end
    end
    // read path: one read outstanding, data from a register
    // only the low address bits decode, so the map repeats every 16 bytes
    if (s_axi_rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_ff.rvalid) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = cpgb_pkg::RESP_OKAY;
      nxt_st.rdata  = 32'h0000_0000;
      unique case (s_axi_araddr[cpgb_pkg::ADDR_W-1:0])
        cpgb_pkg::CAPTURE_COMPARE_DISABLE_OFS: nxt_st.rdata[15:0] = st_ff.dis;
        cpgb_pkg::GATE_STATUS_OFS:             nxt_st.rdata[15:0] = gate_status;
        default:                               nxt_st.rresp = cpgb_pkg::RESP_SLVERR;
      endcase
    end
  end

  // register the whole state; reset leaves every unit enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '{dis: cpgb_pkg::DISABLE_RESET, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // one gate cell per unit; outputs registered inside the cell
  for (genvar i = 0; i < cpgb_pkg::N_UNITS; i++) begin : g_unit
    cpgb_gate_cell u_cap (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .off_in    (st_ff.dis[cpgb_pkg::CAPTURE_LSB+i]),
      .clk_en_ff (cap_clk[i]),
      .pwr_en_ff (capture_pwr_en[i])
    );
    cpgb_gate_cell u_cmp (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .off_in    (st_ff.dis[cpgb_pkg::COMPARE_LSB+i]),
      .clk_en_ff (cmp_clk[i]),
      .pwr_en_ff (compare_pwr_en[i])
    );
  end

  assign capture_clk_en = cap_clk;
  assign compare_clk_en = cmp_clk;
  // live gate state, one means running, same layout as the disable word
  assign gate_status = {2'h0, cap_clk, 2'h0, cmp_clk};

  // bus outputs come straight from the state register
  assign s_axi_awready = !st_ff.aw_held;
  assign s_axi_wready  = !st_ff.w_held;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rresp   = st_ff.rresp;
  assign s_axi_rdata   = st_ff.rdata;

  sequence full_write_s;
    st_ff.aw_held && st_ff.w_held && !st_ff.bvalid &&
    st_ff.aw_addr == cpgb_pkg::CAPTURE_COMPARE_DISABLE_OFS && (&st_ff.w_strb);
  endsequence

  cap_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    full_write_s and st_ff.w_data[cpgb_pkg::CAPTURE_LSB] |-> ##2 !capture_clk_en[0]
      && !capture_pwr_en[0])
    else $error("capture one not gated off after disable write");
  cmp_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    full_write_s and !st_ff.w_data[cpgb_pkg::COMPARE_LSB+5] |-> ##2 compare_clk_en[5])
    else $error("compare six not running after zero written");
  cap_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    full_write_s |-> ##1 st_ff.dis[10:8] == $past(st_ff.w_data[10:8]))
    else $error("capture one to three bits misplaced");
  cap_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
    full_write_s |-> ##1 st_ff.dis[13:11] == $past(st_ff.w_data[13:11]))
    else $error("capture four to six bits misplaced");
  cmp_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
    full_write_s |-> ##1 st_ff.dis[5:0] == $past(st_ff.w_data[5:0]))
    else $error("compare bits misplaced");
  rsvd_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff.dis & ~cpgb_pkg::IMPL_MASK) == 16'h0000)
    else $error("reserved disable bits not zero");
  rst_clear_a: assert property (@(posedge aclk)
    !aresetn |=> st_ff.dis == cpgb_pkg::DISABLE_RESET && !s_axi_bvalid && !s_axi_rvalid)
    else $error("reset did not clear disable word");
  rd_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  wr_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_ff.aw_held && st_ff.w_held && !st_ff.bvalid |=> s_axi_bvalid)
    else $error("write response late");

  // answers stand until the master takes them
  sequence b_wait_s;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  sequence low_lane_s;
    st_ff.aw_held && st_ff.w_held && !st_ff.bvalid && !st_ff.w_strb[1];
  endsequence
  b_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    b_wait_s |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  rd_next_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer not one cycle after address taken");
  rd_word_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready
      && s_axi_araddr[cpgb_pkg::ADDR_W-1:0] == cpgb_pkg::CAPTURE_COMPARE_DISABLE_OFS
      |=> s_axi_rdata == {16'h0000, $past(st_ff.dis)})
    else $error("disable word read back wrong");
  rd_upper_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  // lane 1 left unstrobed must keep the capture bits
  lane_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    low_lane_s |=> $stable(st_ff.dis[cpgb_pkg::CAPTURE_LSB +: cpgb_pkg::N_UNITS]))
    else $error("capture bits changed by a low lane write");

  // enables are the inverse of the disable bits one edge later; clock and power
  // move together so a unit never runs unpowered
  cap_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> capture_clk_en == ~$past(st_ff.dis[cpgb_pkg::CAPTURE_LSB +: cpgb_pkg::N_UNITS])
      && capture_pwr_en == capture_clk_en)
    else $error("capture enables do not follow their disable bits");
  cmp_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> compare_clk_en == ~$past(st_ff.dis[cpgb_pkg::COMPARE_LSB +: cpgb_pkg::N_UNITS])
      && compare_pwr_en == compare_clk_en)
    else $error("compare enables do not follow their disable bits");
endmodule
`default_nettype wire

// >>> pkg/cpgb_pkg.sv
// cpgb_pkg: offsets, field layout and reset value of the capture/compare gate register
// assumes: 32-bit axi4-lite data, one aligned word per register
`default_nettype none
package cpgb_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] CAPTURE_COMPARE_DISABLE_OFS = 4'h0;
  localparam logic [3:0] GATE_STATUS_OFS = 4'h4;
  localparam int unsigned REG_W = 16;
  localparam int unsigned N_UNITS = 6;
  localparam int unsigned COMPARE_LSB = 0;
  localparam int unsigned CAPTURE_LSB = 8;
  localparam logic [15:0] IMPL_MASK = 16'h3f3f;
  localparam logic [15:0] DISABLE_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// >>> src/cpgb_gate_cell.sv
// cpgb_gate_cell: one registered clock/power enable pair for a gated unit
// assumes: off_in comes from the disable register; outputs feed the unit's gates
`default_nettype none
module cpgb_gate_cell (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // control
  input  wire logic off_in,
  // gates
  output var  logic clk_en_ff,
  output var  logic pwr_en_ff
);
  typedef struct packed {
    logic clk_en;
    logic pwr_en;
  } cpgb_cell_t;
  cpgb_cell_t st_ff;
  cpgb_cell_t nxt_st;

  // both sources follow the disable bit together
  always_comb begin
    nxt_st.clk_en = ~off_in;
    nxt_st.pwr_en = ~off_in;
  end

  // unit enabled out of reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '{clk_en: 1'b1, pwr_en: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign clk_en_ff = st_ff.clk_en;
  assign pwr_en_ff = st_ff.pwr_en;

  gate_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> (clk_en_ff == !$past(off_in)) && (pwr_en_ff == clk_en_ff))
    else $error("gate cell enable does not follow disable bit");
endmodule
`default_nettype wire

// >>> tb/cpgb_top_test.sv
// cpgb_top_test: self-checking bench for the capture/compare power gate register
// assumes: cpgb_top alone, axi4-lite master driven here, one 125 mhz clock
`default_nettype none
module cpgb_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic [5:0]  cap_clk, cap_pwr, cmp_clk, cmp_pwr;
  logic [31:0] rd_v;
  int          fails, total_checks;
  int          ans_wait; // edges the master waits before taking an answer
  cpgb_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .capture_clk_en(cap_clk), .capture_pwr_en(cap_pwr),
    .compare_clk_en(cmp_clk), .compare_pwr_en(cmp_pwr));
  // 8 ns clock
  initial begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end
  // one counted compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ready is read at the falling edge, so it is what the next rising edge samples
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, ra, rw, rb;
    ta = 1'h0;
    tw = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= (ans_wait == 0);
    while (!(ta && tw)) begin
      @(negedge aclk);
      ra = awready;
      rw = wready;
      @(posedge aclk);
      if (ra && !ta) begin
        ta = 1'h1;
        awvalid <= 1'h0;
      end
      if (rw && !tw) begin
        tw = 1'h1;
        wvalid <= 1'h0;
      end
    end
    repeat (ans_wait) @(posedge aclk);
    bready <= 1'h1;
    do begin
      @(negedge aclk);
      rb = bvalid;
      rsp = bresp;
      @(posedge aclk);
    end while (!rb);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [31:0] a);
    logic ra, rv;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= (ans_wait == 0);
    do begin
      @(negedge aclk);
      ra = arready;
      @(posedge aclk);
    end while (!ra);
    arvalid <= 1'h0;
    repeat (ans_wait) @(posedge aclk);
    rready <= 1'h1;
    do begin
      @(negedge aclk);
      rv = rvalid;
      rd_v = rdata;
      rsp = rresp;
      @(posedge aclk);
    end while (!rv);
    rready <= 1'h0;
  endtask
  // a set disable bit drops both enables of its unit
  task automatic gates(input logic [15:0] m);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk({18'h0, cap_clk, 2'h0, cmp_clk}, {16'h0, ~m & 16'h3f3f});
    chk({18'h0, cap_pwr, 2'h0, cmp_pwr}, {16'h0, ~m & 16'h3f3f});
    @(posedge aclk);
  endtask
  task automatic t_reset;
    rd(32'h0);
    chk(rd_v, 32'h0);
    gates(16'h0);
    $display("test reset done");
  endtask
  // each of the 16 bits alone; unimplemented ones must not stick
  task automatic t_walk;
    for (int i = 0; i < 16; i++) begin
      wr(32'h0, 32'h1 << i, 4'hf);
      chk({30'h0, rsp}, 32'h0);
      rd(32'h0);
      chk(rd_v, (32'h1 << i) & 32'h3f3f);
      gates(16'h1 << i);
    end
    $display("test walk done");
  endtask
  // byte lanes written apart, then all units back on
  task automatic t_strobe;
    wr(32'h0, 32'h0, 4'hf);
    wr(32'h0, 32'hffff, 4'h1);
    rd(32'h0);
    chk(rd_v, 32'h3f);
    wr(32'h0, 32'hffff, 4'h2);
    rd(32'h0);
    chk(rd_v, 32'h3f3f);
    gates(16'hffff);
    wr(32'h0, 32'h0, 4'hf);
    gates(16'h0);
    $display("test strobe done");
  endtask
  task automatic t_unmapped;
    wr(32'h0, 32'h0a05, 4'hf);
    wr(32'h8, 32'hffff, 4'hf);
    chk({30'h0, rsp}, 32'h2);
    rd(32'h8);
    chk({30'h0, rsp}, 32'h2);
    chk(rd_v, 32'h0);
    wr(32'h4, 32'hffff, 4'hf);
    rd(32'h0);
    chk(rd_v, 32'h0a05);
    rd(32'h4);
    chk(rd_v, 32'h353a);
    $display("test unmapped done");
  endtask
  // slow master: both answers must stand until the ready comes
  task automatic t_slow;
    ans_wait = 3;
    wr(32'h0, 32'h2110, 4'hf);
    chk({30'h0, rsp}, 32'h0);
    rd(32'h0);
    chk(rd_v, 32'h2110);
    ans_wait = 0;
    gates(16'h2110);
    $display("test slow done");
  endtask
  // reset in mid-run clears every disable bit again
  task automatic t_rerst;
    wr(32'h0, 32'h3f3f, 4'hf);
    gates(16'h3f3f);
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    gates(16'h0);
    rd(32'h0);
    chk(rd_v, 32'h0);
    $display("test mid reset done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    summarize();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, wdata, araddr, wstrb} = 100'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset();
    t_walk();
    t_strobe();
    t_unmapped();
    t_slow();
    t_rerst();
    summarize();
  end
endmodule
`default_nettype wire
